// >>> shared/eaifm_pkg.sv
// Constants and types for the engine analog input fault monitor.
// Assumes a 40 MHz system clock and one 10-bit converter code per analog pin.
package eaifm_pkg;
  // ---------------------------------------------------------------
  // Sizes and clock
  // ---------------------------------------------------------------
  localparam int NUM_IN = 6;
  localparam int CODE_W = 10;
  localparam int VAL_W = 16;
  localparam int RPM_W = 16;
  localparam int BYP_W = 8;
  localparam int DIV_NUM_W = 24;
  localparam int DIV_DEN_W = 12;
  localparam int CLK_HZ = 40_000_000;
  localparam int EVAL_US = 1000;
  localparam int EVAL_CYC = EVAL_US * (CLK_HZ / 1_000_000);
  localparam int SEC_S = 1;
  localparam int SEC_CYC = SEC_S * CLK_HZ;

  // ---------------------------------------------------------------
  // Analog levels, millivolts and ohms
  // ---------------------------------------------------------------
  localparam int FS_CODE = 1023;
  localparam logic [CODE_W-1:0] CODE_FS = 10'h3FF;
  localparam int FS_MV = 5000;
  localparam int OPEN_MV = 4760;
  localparam int SHORT_MV = 122;
  localparam int CLOSED_MV = 2500;
  localparam int PU_LOW = 1000;
  localparam int PU_HIGH = 5110;
  localparam int LOW_RES_MAX = 500;
  localparam int GAIN_HI = 3;

  // ---------------------------------------------------------------
  // Input types and pins
  // ---------------------------------------------------------------
  localparam logic [2:0] T_HI_TEMP = 3'h0;
  localparam logic [2:0] T_OIL_PRES = 3'h1;
  localparam logic [2:0] T_FUEL = 3'h2;
  localparam logic [2:0] T_OIL_LVL = 3'h3;
  localparam logic [2:0] T_BASIN = 3'h4;
  localparam logic [2:0] T_LO_TEMP = 3'h5;
  localparam logic [2:0] PIN_FIRST = 3'h2;
  localparam logic [2:0] PIN_LAST = 3'h7;

  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_TBL0 = 3'h0, SRC_TBL1 = 3'h1, SRC_TBL2 = 3'h2, SRC_NET = 3'h3, SRC_SW = 3'h4
  } eaifm_src_t;
  typedef enum logic [1:0] {ACT_OFF = 2'h0, ACT_WARN = 2'h1, ACT_FAIL = 2'h2} eaifm_act_t;
  typedef enum logic {SPD_MAG = 1'h0, SPD_GEN = 1'h1} eaifm_spd_t;

  // Sender curves: value = offset - (ohms * slope) / 256, entry 3 unused
  localparam logic [3:0][VAL_W-1:0] TBL_OFS = {16'h0000, 16'h00C8, 16'h0064, 16'h0096};
  localparam logic [3:0][VAL_W-1:0] TBL_SLOPE = {16'h0000, 16'h0080, 16'h0100, 16'h0040};
endpackage : eaifm_pkg

// >>> src/eaifm_div.sv
// Restoring divider used to turn a pin code into sender ohms.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module eaifm_div #(
  parameter int NUM_W = eaifm_pkg::DIV_NUM_W,
  parameter int DEN_W = eaifm_pkg::DIV_DEN_W,
  parameter int Q_W = eaifm_pkg::VAL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [DEN_W-1:0] den,
  // Result
  output logic done,
  output logic [Q_W-1:0] quo
);
  import eaifm_pkg::*;

  if (NUM_W <= Q_W || DEN_W < 2) begin : g_bad_param
    $error("eaifm_div: widths out of range");
  end

  localparam int CW = $clog2(NUM_W + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [DEN_W:0] rem;
    logic [DEN_W-1:0] d;
    logic [NUM_W-1:0] n;
    logic [NUM_W-1:0] q;
  } eaifm_div_t;
  eaifm_div_t s_q, s_d;
  logic [DEN_W:0] rem_sh;

  // One quotient bit a cycle; a zero divisor saturates the result
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    rem_sh = {s_q.rem[DEN_W-1:0], s_q.n[NUM_W-1]};
    if (start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.cnt = '0;
      s_d.rem = '0;
      s_d.d = den;
      s_d.n = num;
      s_d.q = '0;
    end else if (s_q.busy) begin
      s_d.n = {s_q.n[NUM_W-2:0], 1'b0};
      if (rem_sh >= {1'b0, s_q.d}) begin
        s_d.rem = rem_sh - {1'b0, s_q.d};
        s_d.q = {s_q.q[NUM_W-2:0], 1'b1};
      end else begin
        s_d.rem = rem_sh;
        s_d.q = {s_q.q[NUM_W-2:0], 1'b0};
      end
      s_d.cnt = s_q.cnt + 1'b1;
      if (s_q.cnt == CW'(NUM_W - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end

  assign done = s_q.done;
  assign quo = (|s_q.q[NUM_W-1:Q_W]) ? '1 : s_q.q[Q_W-1:0];
endmodule : eaifm_div

// >>> src/eaifm_byp.sv
// Bypass timer for one analog input, counted in one-second ticks.
// Assumes crank_ok is a pulse on crank success and engine_stop a level.
`timescale 1ns/1ps
module eaifm_byp #(
  parameter int CNT_W = eaifm_pkg::BYP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Engine events
  input wire logic crank_ok,
  input wire logic engine_stop,
  input wire logic sec_tick,
  // Setting and result
  input wire logic [CNT_W-1:0] len,
  output logic expired
);
  import eaifm_pkg::*;

  if (CNT_W < 1) begin : g_bad_param
    $error("eaifm_byp: counter width out of range");
  end

  typedef struct packed {
    logic run;
    logic done;
    logic [CNT_W-1:0] cnt;
  } eaifm_byp_t;
  eaifm_byp_t s_q, s_d;

  // Stop re-arms the bypass; it only opens after the next crank success
  always_comb begin
    s_d = s_q;
    if (engine_stop) begin
      s_d.run = 1'b0;
      s_d.done = 1'b0;
    end else if (crank_ok) begin
      s_d.cnt = len;
      s_d.run = (len != '0);
      s_d.done = (len == '0);
    end else if (s_q.run && sec_tick) begin
      s_d.cnt = s_q.cnt - 1'b1;
      if (s_q.cnt <= CNT_W'(1)) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end

  assign expired = s_q.done;
endmodule : eaifm_byp

// >>> src/eaifm_top.sv
// Engine analog input fault monitor: six inputs, speed limits, fault outputs.
// Assumes pin codes and settings are synchronous to clk and held between changes.
`timescale 1ns/1ps
// Summary of operation
// (R1) Switch fault: closed or open per setting
// (R2) Switch input shows contact indicator, not value
// (R3) Switch trips shutdown; fuel may only warn
// (R4) Disabled pin: virtual 5 V closed-fail switch
// (R5) Per-input bypass after crank suppresses checks
// (R6) After bypass, warn alarms, fail shuts down
// (R7) High temp trips above, others below
// (R8) Thresholds apply to sender sources only
// (R9) Oil level, basin warnings ignore bypass
// (R10) Open sender above 4.76 V, configurable action
// (R11) Shorted sender below 0.122 V, configurable action
// (R12) Negative temperature clamped to zero for checks
// (R13) Fuel sender points strictly monotonic, configurer's duty
// (R14) Ohms from voltage with 1k/5.11k pull-up
// (R15) Gain of three except pins 2, 6
// (R16) Three tables, network, switch; tables pins 3-4
// (R17) Low-resistance senders on low-resistance pins only
// (R18) Speed from pickup or generator frequency
// (R19) Over/under speed limits in RPM, any source
// (R20) One pin per type except temperature pair
// (R21) Fault outputs registered, updated each evaluation
module eaifm_top #(
  parameter int EVAL_CYCLES = eaifm_pkg::EVAL_CYC,
  parameter int SEC_CYCLES = eaifm_pkg::SEC_CYC,
  parameter int BYP_W = eaifm_pkg::BYP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin readings, entry 0 is pin 2; network values by input type
  input wire logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::CODE_W-1:0] pin_code,
  input wire logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::VAL_W-1:0] network_value_source,
  // Per input type settings
  input wire logic [eaifm_pkg::NUM_IN-1:0][2:0] pin_sel,
  input wire logic [eaifm_pkg::NUM_IN-1:0][2:0] src_sel,
  input wire logic [eaifm_pkg::NUM_IN-1:0] closed_fail,
  input wire logic [eaifm_pkg::NUM_IN-1:0][1:0] open_act,
  input wire logic [eaifm_pkg::NUM_IN-1:0][1:0] short_act,
  input wire logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::VAL_W-1:0] warn_thr,
  input wire logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::VAL_W-1:0] fail_thr,
  input wire logic [eaifm_pkg::NUM_IN-1:0][BYP_W-1:0] bypass_len,
  input wire logic fuel_sw_warn,
  // Engine state
  input wire logic crank_ok,
  input wire logic engine_stop,
  // Speed
  input wire logic spd_src,
  input wire logic [eaifm_pkg::RPM_W-1:0] mag_rpm,
  input wire logic [eaifm_pkg::RPM_W-1:0] gen_rpm,
  input wire logic [eaifm_pkg::RPM_W-1:0] ovs_warn_rpm,
  input wire logic [eaifm_pkg::RPM_W-1:0] ovs_fail_rpm,
  input wire logic [eaifm_pkg::RPM_W-1:0] uns_warn_rpm,
  input wire logic [eaifm_pkg::RPM_W-1:0] uns_fail_rpm,
  // Per input results
  output logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::VAL_W-1:0] disp_value,
  output logic [eaifm_pkg::NUM_IN-1:0] contact_indicator,
  output logic [eaifm_pkg::NUM_IN-1:0] in_warn,
  output logic [eaifm_pkg::NUM_IN-1:0] in_fail,
  output logic [eaifm_pkg::NUM_IN-1:0] cfg_err,
  // Summary results
  output logic alarm,
  output logic shutdown,
  output logic eval_done,
  output logic [eaifm_pkg::RPM_W-1:0] spd_rpm,
  output logic ovs_warn,
  output logic ovs_fail,
  output logic uns_warn,
  output logic uns_fail
);
  import eaifm_pkg::*;

  if (EVAL_CYCLES < 256 || SEC_CYCLES < 2 || BYP_W < 1) begin : g_bad_param
    $error("eaifm_top: parameters out of range");
  end

  localparam int TW = $clog2(EVAL_CYCLES + 1);
  localparam int SW = $clog2(SEC_CYCLES + 1);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Pin number is live only from 2 to 7
  function automatic logic pin_ok(input logic [2:0] sel);
    return sel >= PIN_FIRST && sel <= PIN_LAST;
  endfunction : pin_ok

  // Pin voltage against a millivolt level, undoing the pin gain
  function automatic logic mv_cmp(input logic [CODE_W-1:0] code, input logic g3,
                                  input int mv, input logic above);
    int lhs;
    int rhs;
    lhs = int'(code) * FS_MV;
    rhs = mv * FS_CODE * (g3 ? GAIN_HI : 1);
    return above ? (lhs > rhs) : (lhs < rhs);
  endfunction : mv_cmp

  // Sender curve from ohms to engineering value
  function automatic logic signed [VAL_W-1:0] tbl_val(input logic [1:0] t,
                                                      input logic [VAL_W-1:0] r);
    logic [31:0] p;
    p = 32'(r) * 32'(TBL_SLOPE[t]);
    return $signed(TBL_OFS[t]) - $signed({1'b0, p[VAL_W+6:8]});
  endfunction : tbl_val

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_LOAD = 4'h2, ST_WAIT = 4'h4, ST_EVAL = 4'h8
  } eaifm_st_t;

  typedef struct packed {
    eaifm_st_t st;
    logic [2:0] idx;
    logic [TW-1:0] tmr;
    logic [SW-1:0] sec;
    logic sec_tick;
    logic div_go;
    logic [CODE_W-1:0] code;
    logic gain3;
    logic pu_hi;
    logic [NUM_IN-1:0][VAL_W-1:0] disp;
    logic [NUM_IN-1:0] ind;
    logic [NUM_IN-1:0] warn;
    logic [NUM_IN-1:0] fail;
    logic [NUM_IN-1:0] tbl_err;
    logic [NUM_IN-1:0] cfg_err;
    logic alarm;
    logic shut;
    logic done;
    logic [RPM_W-1:0] rpm;
    logic ovs_w;
    logic ovs_f;
    logic uns_w;
    logic uns_f;
  } eaifm_state_t;
  eaifm_state_t s_q, s_d;

  logic [2:0] e_i, e_sel;
  logic [2:0] e_src;
  logic e_on, e_cf, e_sw, e_net, e_tbl, e_tbl_ok, e_glob, e_byp;
  logic e_closed, e_open, e_short, e_fault, e_tw, e_tf, e_w, e_f;
  logic signed [VAL_W-1:0] e_val, e_cv;
  logic [NUM_IN-1:0] e_share;
  logic [RPM_W-1:0] e_rpm;
  logic div_done;
  logic [VAL_W-1:0] res_ohm;
  logic [DIV_NUM_W-1:0] div_num;
  logic [DIV_DEN_W-1:0] div_den;
  logic [NUM_IN-1:0] byp_done;

  // ---------------------------------------------------------------
  // Ohms from the latched code, pull-up and gain
  // ---------------------------------------------------------------
  assign div_num = DIV_NUM_W'(int'(s_q.code) * (s_q.pu_hi ? PU_HIGH : PU_LOW)); // R14
  assign div_den = DIV_DEN_W'((s_q.gain3 ? GAIN_HI : 1) * FS_CODE - int'(s_q.code)); // R14

  eaifm_div u_div (
    .clk(clk),
    .rst(rst),
    .start(s_q.div_go),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(res_ohm)
  );

  // One bypass timer per input type
  for (genvar g = 0; g < NUM_IN; g++) begin : g_byp
    eaifm_byp #(.CNT_W(BYP_W)) u_byp (
      .clk(clk),
      .rst(rst),
      .crank_ok(crank_ok),
      .engine_stop(engine_stop),
      .sec_tick(s_q.sec_tick),
      .len(bypass_len[g]),
      .expired(byp_done[g])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.div_go = 1'b0;
    s_d.done = 1'b0;
    s_d.sec_tick = 1'b0;
    // Free-running timers so the evaluation period never drifts
    s_d.tmr = (s_q.tmr == TW'(EVAL_CYCLES - 1)) ? '0 : s_q.tmr + 1'b1;
    s_d.sec = (s_q.sec == SW'(SEC_CYCLES - 1)) ? '0 : s_q.sec + 1'b1;
    s_d.sec_tick = (s_q.sec == SW'(SEC_CYCLES - 1));

    // Settings of the input under evaluation; a dead pin is a virtual switch
    e_i = s_q.idx;
    e_sel = pin_sel[e_i];
    e_on = pin_ok(e_sel);
    e_src = e_on ? src_sel[e_i] : SRC_SW; // R4
    e_cf = e_on ? closed_fail[e_i] : 1'b1; // R4
    e_sw = (e_src == SRC_SW);
    e_net = (e_src == SRC_NET);
    e_tbl = !e_sw && !e_net;
    e_tbl_ok = (e_sel == 3'h3 || e_sel == 3'h4); // R16 R17
    e_glob = (e_i == T_OIL_LVL || e_i == T_BASIN);
    e_byp = byp_done[e_i];
    e_closed = mv_cmp(s_q.code, s_q.gain3, CLOSED_MV, 1'b0);
    e_open = mv_cmp(s_q.code, s_q.gain3, OPEN_MV, 1'b1); // R10
    e_short = mv_cmp(s_q.code, s_q.gain3, SHORT_MV, 1'b0); // R11
    e_fault = e_cf ? e_closed : !e_closed; // R1
    e_val = tbl_val(e_src[1:0], res_ohm);
    // Below-zero temperature counts as zero for the limits
    e_cv = ((e_i == T_HI_TEMP || e_i == T_LO_TEMP) && e_val < 0) ? '0 : e_val; // R12
    e_tw = (e_i == T_HI_TEMP) ? (e_cv > $signed(warn_thr[e_i])) // R7
                              : (e_cv < $signed(warn_thr[e_i]));
    e_tf = (e_i == T_HI_TEMP) ? (e_cv > $signed(fail_thr[e_i])) // R7
                              : (e_cv < $signed(fail_thr[e_i]));

    // Raw warning and failure; open and short need no valid table
    e_w = 1'b0;
    e_f = 1'b0;
    if (e_sw) begin
      if (e_i == T_FUEL && fuel_sw_warn) e_w = e_fault; // R3
      else e_f = e_fault; // R3
    end else if (e_tbl) begin // R8
      e_w = (e_tbl_ok && e_tw) || (e_open && open_act[e_i] == ACT_WARN) // R10 R16
          || (e_short && short_act[e_i] == ACT_WARN); // R11
      e_f = (e_tbl_ok && e_tf) || (e_open && open_act[e_i] == ACT_FAIL) // R10 R16
          || (e_short && short_act[e_i] == ACT_FAIL); // R11
    end

    // Scan sequence: latch a pin, divide, then judge the input
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.tmr == TW'(EVAL_CYCLES - 1)) s_d.st = ST_LOAD;
      end
      ST_LOAD: begin
        s_d.code = e_on ? pin_code[3'(e_sel - PIN_FIRST)] : CODE_FS; // R4
        s_d.gain3 = e_on && e_sel != 3'h2 && e_sel != 3'h6; // R15
        s_d.pu_hi = (e_sel >= 3'h5); // R14
        s_d.div_go = 1'b1;
        s_d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (div_done) s_d.st = ST_EVAL;
      end
      ST_EVAL: begin
        s_d.ind[e_i] = e_sw; // R2
        s_d.disp[e_i] = e_sw ? '0 : (e_net ? network_value_source[e_i] : e_val); // R2
        s_d.tbl_err[e_i] = e_tbl && !e_tbl_ok; // R16 R17
        s_d.warn[e_i] = e_w && (e_glob || e_byp); // R5 R9 R21
        s_d.fail[e_i] = e_f && e_byp; // R5 R21
        if (s_q.idx == 3'(NUM_IN - 1)) begin
          s_d.idx = '0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end else begin
          s_d.idx = s_q.idx + 1'b1;
          s_d.st = ST_LOAD;
        end
      end
      default: begin
        s_d.idx = '0;
        s_d.st = ST_IDLE;
      end
    endcase

    // A stop drops failures; global warnings carry on
    if (engine_stop) s_d.fail = '0; // R21

    // Two types on one pin, temperature pair excepted
    e_share = '0;
    for (int a = 0; a < NUM_IN; a++) begin
      for (int b = a + 1; b < NUM_IN; b++) begin
        if (pin_ok(pin_sel[a]) && pin_sel[a] == pin_sel[b]
            && !(3'(a) == T_HI_TEMP && 3'(b) == T_LO_TEMP)) begin // R20
          e_share[a] = 1'b1;
          e_share[b] = 1'b1;
        end
      end
    end
    s_d.cfg_err = e_share | s_d.tbl_err; // R20
    s_d.alarm = |(s_d.warn | s_d.fail); // R6
    s_d.shut = |s_d.fail; // R6

    // Speed limits on whichever source is chosen
    e_rpm = (spd_src == SPD_GEN) ? gen_rpm : mag_rpm; // R18
    s_d.rpm = e_rpm;
    s_d.ovs_w = e_rpm > ovs_warn_rpm; // R19
    s_d.ovs_f = e_rpm > ovs_fail_rpm; // R19
    // Under-speed is meaningless with the engine stopped
    s_d.uns_w = !engine_stop && e_rpm < uns_warn_rpm; // R19
    s_d.uns_f = !engine_stop && e_rpm < uns_fail_rpm; // R19
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign disp_value = s_q.disp;
  assign contact_indicator = s_q.ind;
  assign in_warn = s_q.warn;
  assign in_fail = s_q.fail;
  assign cfg_err = s_q.cfg_err;
  assign alarm = s_q.alarm;
  assign shutdown = s_q.shut;
  assign eval_done = s_q.done;
  assign spd_rpm = s_q.rpm;
  assign ovs_warn = s_q.ovs_w;
  assign ovs_fail = s_q.ovs_f;
  assign uns_warn = s_q.uns_w;
  assign uns_fail = s_q.uns_f;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sw_fault_a: assert property (@(posedge clk) disable iff (rst) // R1
    s_q.st == ST_EVAL && e_sw && e_fault && e_byp && !engine_stop && e_i != T_FUEL
    |=> s_q.fail[$past(s_q.idx)] ##0 shutdown) else $error("switch fault not raised");

  sw_ind_a: assert property (@(posedge clk) disable iff (rst) // R2
    s_q.st == ST_EVAL |=> contact_indicator[$past(s_q.idx)] == $past(e_sw))
    else $error("contact indicator wrong");

  fuel_warn_a: assert property (@(posedge clk) disable iff (rst) // R3
    s_q.st == ST_EVAL && e_sw && e_i == T_FUEL && fuel_sw_warn
    |=> !in_fail[T_FUEL]) else $error("fuel switch failed instead of warning");

  virt_pin_a: assert property (@(posedge clk) disable iff (rst) // R4
    s_q.st == ST_EVAL && !e_on
    |=> !in_warn[$past(s_q.idx)] && !in_fail[$past(s_q.idx)])
    else $error("disabled pin tripped");

  byp_hold_a: assert property (@(posedge clk) disable iff (rst) // R5
    s_q.st == ST_EVAL && !e_byp |=> !in_fail[$past(s_q.idx)])
    else $error("failure during bypass");

  thr_fail_a: assert property (@(posedge clk) disable iff (rst) // R7
    s_q.st == ST_EVAL && e_tbl && e_tbl_ok && e_tf && e_byp && !engine_stop
    |=> shutdown && alarm) else $error("threshold failure missed");

  net_nochk_a: assert property (@(posedge clk) disable iff (rst) // R8
    s_q.st == ST_EVAL && e_net
    |=> !in_warn[$past(s_q.idx)] && !in_fail[$past(s_q.idx)])
    else $error("network source checked");

  glob_warn_a: assert property (@(posedge clk) disable iff (rst) // R9
    s_q.st == ST_EVAL && e_glob && e_w |=> in_warn[$past(s_q.idx)])
    else $error("global warning suppressed");

  open_fail_a: assert property (@(posedge clk) disable iff (rst) // R10
    s_q.st == ST_EVAL && e_tbl && e_open && open_act[e_i] == ACT_FAIL
    && e_byp && !engine_stop |=> shutdown) else $error("open sender missed");

  ovs_fail_a: assert property (@(posedge clk) disable iff (rst) // R19
    ((spd_src == SPD_GEN) ? gen_rpm : mag_rpm) > ovs_fail_rpm |=> ovs_fail)
    else $error("overspeed missed");
endmodule : eaifm_top

// >>> sim/eaifm_senders.sv
// Engine side model: sender levels on the six pins and both speed sources.
// Assumes levels come as converter codes already scaled by the pin gain.
`timescale 1ns/1ps
module eaifm_senders #(
  parameter logic [15:0] SLIP = 16'h0064
) (
  // Clock
  input wire logic clk,
  // Wanted engine conditions
  input wire logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::CODE_W-1:0] lvl,
  input wire logic [eaifm_pkg::RPM_W-1:0] rpm,
  // Pins and pickups
  output logic [eaifm_pkg::NUM_IN-1:0][eaifm_pkg::CODE_W-1:0] pin_code,
  output logic [eaifm_pkg::RPM_W-1:0] mag_rpm,
  output logic [eaifm_pkg::RPM_W-1:0] gen_rpm
);
  import eaifm_pkg::*;
  // Senders settle a clock late; generator speed lags by slip, so sources differ
  always_ff @(posedge clk) begin
    pin_code <= lvl;
    mag_rpm <= rpm;
    gen_rpm <= rpm - SLIP;
  end
endmodule : eaifm_senders

// >>> sim/eaifm_top_test.sv
// Bench for the fault monitor: switches, bypass, thresholds, sender faults, speed.
// Assumes the engine side model and shortened scan and second counts.
`timescale 1ns/1ps
module eaifm_top_test;
  import eaifm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 0, rst = 1, crank_ok = 0, engine_stop = 1, spd_src = 0, fuel_sw_warn = 0;
  logic eval_done, alarm, shutdown, ovs_warn, ovs_fail, uns_warn, uns_fail;
  logic [NUM_IN-1:0][CODE_W-1:0] pin_lvl = '0, pin_code;
  logic [NUM_IN-1:0][VAL_W-1:0] net_val = '0, warn_thr = '0, fail_thr = '0, disp_value;
  logic [NUM_IN-1:0][2:0] pin_sel = '0, src_sel = '0;
  logic [NUM_IN-1:0][1:0] open_act = '0, short_act = '0;
  logic [NUM_IN-1:0][7:0] bypass_len = '0;
  logic [NUM_IN-1:0] closed_fail = '0, contact_indicator, in_warn, in_fail, cfg_err;
  logic [RPM_W-1:0] eng_rpm = 16'h0708, mag_rpm, gen_rpm, spd_rpm;
  logic [RPM_W-1:0] ow = 16'h0BB8, of = 16'h0C80, uw = 16'h0578, uf = 16'h04B0;
  logic [45:0] notes[$];
  logic [45:0] exp_n, got_n;
  logic trip;
  int err_count = 0, cmp_count = 0, cyc = 0, seed;

  always #12.5 clk = ~clk;

  eaifm_senders eaifm_senders_inst (.clk(clk), .lvl(pin_lvl), .rpm(eng_rpm),
    .pin_code(pin_code), .mag_rpm(mag_rpm), .gen_rpm(gen_rpm));

  eaifm_top #(.EVAL_CYCLES(300), .SEC_CYCLES(50)) eaifm_top_inst (.clk(clk), .rst(rst),
    .pin_code(pin_code), .network_value_source(net_val), .pin_sel(pin_sel),
    .src_sel(src_sel), .closed_fail(closed_fail), .open_act(open_act),
    .short_act(short_act), .warn_thr(warn_thr), .fail_thr(fail_thr),
    .bypass_len(bypass_len), .fuel_sw_warn(fuel_sw_warn), .crank_ok(crank_ok),
    .engine_stop(engine_stop), .spd_src(spd_src), .mag_rpm(mag_rpm), .gen_rpm(gen_rpm),
    .ovs_warn_rpm(ow), .ovs_fail_rpm(of), .uns_warn_rpm(uw), .uns_fail_rpm(uf),
    .disp_value(disp_value), .contact_indicator(contact_indicator), .in_warn(in_warn),
    .in_fail(in_fail), .cfg_err(cfg_err), .alarm(alarm), .shutdown(shutdown),
    .eval_done(eval_done), .spd_rpm(spd_rpm), .ovs_warn(ovs_warn), .ovs_fail(ovs_fail),
    .uns_warn(uns_warn), .uns_fail(uns_fail));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Expected speed and flags; underspeed is silent while stopped
  function automatic logic [19:0] exp_spd();
    logic [RPM_W-1:0] s;
    s = spd_src ? eng_rpm - 16'h0064 : eng_rpm;
    return {s, s > ow, s > of, !engine_stop && s < uw, !engine_stop && s < uf};
  endfunction : exp_spd

  // One scan is skipped since settings may change mid-scan
  task automatic check(input string nm, input logic [5:0] w, f, ind,
                       input logic [5:0] c = 6'h00);
    @(posedge clk);
    eng_rpm <= 16'($urandom_range(3400, 1000));
    spd_src <= 1'($urandom_range(1, 0));
    @(negedge clk);
    while (eval_done !== 1'b1) @(negedge clk);
    @(posedge clk);
    notes.push_back({w, f, ind, c, |{w, f}, |f, exp_spd()});
    while (notes.size() > 0) @(negedge clk);
    $display("test %s done", nm);
  endtask : check

  // Stop re-arms every bypass timer, crank success starts them
  task automatic run_engine();
    @(posedge clk) engine_stop <= 1'b1;
    @(posedge clk) engine_stop <= 1'b0;
    @(posedge clk) crank_ok <= 1'b1;
    @(posedge clk) crank_ok <= 1'b0;
  endtask : run_engine

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Oldest note is compared whenever a scan completes
  always @(negedge clk) begin
    if (eval_done === 1'b1 && notes.size() > 0) begin
      exp_n = notes.pop_front();
      got_n = {in_warn, in_fail, contact_indicator, cfg_err, alarm, shutdown, spd_rpm,
        ovs_warn, ovs_fail, uns_warn, uns_fail};
      cmp_count++;
      if (got_n !== exp_n) begin
        err_count++;
        $display("unexpected flags: expected %h seen %h", exp_n, got_n);
      end
    end
  end

  // Hang guard, well above the roughly 13000 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = $urandom(32'h9D99F9CF);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    run_engine();
    check("disabled", 6'h00, 6'h00, 6'h3F);
    // Switches on full-range pins 2 and 6; fuel switch set to warn only
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      pin_sel <= {3'h0, 3'h0, 3'h0, 3'h6, 3'h2, 3'h0};
      src_sel <= {3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h0};
      closed_fail <= {6{k[0]}};
      fuel_sw_warn <= 1'b1;
      pin_lvl <= k[1] ? {6{CODE_FS}} : '0;
      trip = k[0] ^ k[1];
      check("switch", {3'h0, trip, 2'h0}, {4'h0, trip, 1'b0}, 6'h3F);
    end
    // Closed contacts with a 100 s bypass on oil pressure only
    @(posedge clk);
    pin_lvl <= '0;
    bypass_len[1] <= 8'h64;
    run_engine();
    check("bypass on", 6'h04, 6'h00, 6'h3F);
    repeat (5000) @(posedge clk);
    check("bypass off", 6'h04, 6'h02, 6'h3F);
    // High temp on pin 3, oil level on pin 4, network oil pressure on pin 5
    @(posedge clk);
    bypass_len <= '0;
    pin_sel <= {3'h0, 3'h0, 3'h4, 3'h0, 3'h5, 3'h3};
    src_sel <= {3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h0};
    warn_thr <= {32'h0, 16'h00C8, 16'h0000, 16'h0032, 16'h0064};
    fail_thr <= {32'h0, 16'h00C8, 32'h0, 16'h00C8};
    check("thresholds", 6'h09, 6'h08, 6'h34);
    // Negative reading clamps to zero, above a negative threshold
    @(posedge clk);
    src_sel[0] <= SRC_TBL1;
    pin_lvl[1] <= CODE_FS;
    warn_thr[0] <= 16'hFFF6;
    check("clamp", 6'h09, 6'h08, 6'h34);
    // Display keeps the unclamped reading of table 1 at 500 ohms
    cmp_count++;
    if (disp_value[0] !== 16'hFE70) begin
      err_count++;
      $display("unexpected disp_value[0]: expected FE70 seen %h", disp_value[0]);
    end
    @(posedge clk) engine_stop <= 1'b1;
    check("global", 6'h08, 6'h00, 6'h34);
    // Open sender on pin 2 and shorted sender on pin 3, every action
    @(posedge clk);
    pin_sel <= {3'h0, 3'h2, 3'h0, 3'h2, 3'h3, 3'h0};
    src_sel <= '0;
    warn_thr <= '0;
    fail_thr <= '0;
    pin_lvl <= {40'h0, 10'h000, 10'h3FF};
    run_engine();
    for (int a = 0; a < 3; a++) begin
      @(posedge clk);
      open_act <= 12'(a) << 8;
      short_act <= 12'(a) << 2;
      check("sender", (a == 1) ? 6'h12 : 6'h00, (a == 2) ? 6'h12 : 6'h00,
            6'h29, 6'h14);
    end
    complete_run();
  end
endmodule : eaifm_top_test
